// file: rtl/pfa_top.sv
// parser header flags and association stage for named header channels
`timescale 1ns/1ps
`default_nettype none
module pfa_top
	import pfa_pkg::*;
#(
	parameter logic [FLAG_W-1:0] FWD_MASK = {FLAG_W{1'b1}}
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// frame framing from the slice array
	input wire logic FRAME_START,
	input wire logic FRAME_END,
	// per slice step
	input wire logic SLICE_VALID,
	input wire logic [31:0] FRAME_DATA,
	input wire logic LOW_HALF_SUM_ENABLE,
	input wire logic HIGH_HALF_SUM_ENABLE,
	input wire logic [FLAG_W-1:0] FLAG_SET_ACTION,
	input wire logic LENGTH_CHECK_FAIL,
	input wire logic SLICE_TERMINATE,
	// memory parity error, any cycle of a frame
	input wire logic TABLE_PARITY_ERR,
	// final generic field channels, flattened
	input wire logic [NUM_CHAN*CHAN_W-1:0] FIELDS,
	// status
	output logic BUSY,
	output logic RESULT_VALID,
	// header flags
	output logic [FLAG_W-1:0] FLAGS_OUT,
	output logic [FLAG_W-1:0] ACTION_FLAGS,
	// named channels
	output logic [QOS_W-1:0] QOS,
	output logic [2:0] TAG_FRAME_TYPE,
	output logic [1:0] TAG_VLAN_TYPE,
	output logic [7:0] TAG_USER_BITS,
	output logic [11:0] OUTER_VLAN_ID,
	output logic [11:0] INNER_VLAN_ID,
	output logic [15:0] SOURCE_PORT_TAG,
	output logic [15:0] DEST_PORT_TAG,
	output logic [47:0] DEST_MAC_CHAN,
	output logic [47:0] SOURCE_MAC_CHAN,
	output logic [15:0] ETHERTYPE_CHAN,
	output logic [19:0] FLOW_LABEL_CHAN,
	output logic [15:0] IP_LENGTH_CHAN,
	output logic [7:0] HOP_LIMIT_CHAN,
	output logic [7:0] L4_PROTOCOL_CHAN
);
	// the three hardware-owned flags must fit inside the flag vector
	if (FLAG_W <= FLAG_PARITY_BIT) begin : g_chk
		$error("flag vector too narrow for fixed-function bits");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} pfa_state_t;

	typedef struct packed {
		pfa_state_t st;
		logic term;
		logic [FLAG_W-1:0] flags;
		logic [15:0] sum;
		logic [FLAG_W-1:0] flags_out;
		logic [QOS_W-1:0] qos;
		logic [2:0] ftype;
		logic [1:0] vtype;
		logic [7:0] user;
		logic [11:0] ovid;
		logic [11:0] ivid;
		logic [15:0] src_tag;
		logic [15:0] dst_tag;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [15:0] etype;
		logic [19:0] flow;
		logic [15:0] iplen;
		logic [7:0] hop;
		logic [7:0] l4;
	} pfa_regs_t;

	pfa_regs_t st_r;
	pfa_regs_t st_nxt;
	logic [15:0] sum_upd;
	logic step;
	logic [FLAG_W-1:0] flags_step;
	logic [CHAN_W-1:0] fch [NUM_CHAN];

	// a slice step only counts while the frame is open and not terminated
	assign step = (st_r.st == ST_BUSY) && SLICE_VALID && !st_r.term;

	// each slice picks which halves of its window join the sum [R20]
	pfa_csum_add u_csum (
		.acc(st_r.sum),
		.low_half(FRAME_DATA[15:0]),
		.high_half(FRAME_DATA[31:16]),
		.low_en(LOW_HALF_SUM_ENABLE),
		.high_en(HIGH_HALF_SUM_ENABLE),
		.sum(sum_upd)
	);

	// unpack the flat field bus once so channels can be sliced by index
	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			fch[i] = FIELDS[i*CHAN_W +: CHAN_W];
		end
	end

	// flag vector after this cycle's slice step and parity report
	always_comb begin
		flags_step = st_r.flags;
		if (step) begin
			// microcode action is the only path for ordinary bits [R4]
			flags_step = flags_step | FLAG_SET_ACTION; // [R4]
			if (LENGTH_CHECK_FAIL) begin
				flags_step[FLAG_SHORT_BIT] = 1'b1; // [R2]
			end
		end
		// parity is a hardware fault, so it lands even after terminate
		if (st_r.st == ST_BUSY && TABLE_PARITY_ERR) begin
			flags_step[FLAG_PARITY_BIT] = 1'b1; // [R3]
		end
	end

	// next state of the whole block
	always_comb begin
		st_nxt = st_r;
		case (st_r.st)
			ST_IDLE, ST_DONE: begin
				st_nxt.st = ST_IDLE;
				if (FRAME_START) begin
					st_nxt.st = ST_BUSY;
					st_nxt.term = 1'b0;
					st_nxt.flags = '0;
					st_nxt.sum = CSUM_INIT;
				end
			end
			ST_BUSY: begin
				st_nxt.flags = flags_step;
				if (step) begin
					st_nxt.sum = sum_upd; // [R20]
					st_nxt.term = SLICE_TERMINATE;
				end
				if (FRAME_END) begin
					st_nxt.st = ST_DONE;
					// final test on the sum including this cycle's slice
					if (flags_step[FLAG_CSUM_BIT] &&
							st_nxt.sum == CSUM_GOOD) begin
						st_nxt.flags[FLAG_CSUM_BIT] = 1'b0; // [R1]
					end
					st_nxt.flags_out = st_nxt.flags;
					// routing only; the compositions are the qos vector and the flow label [R6]
					st_nxt.qos[QOS_SW_LSB +: 4] =
						fch[CH_TAG][11:8]; // [R8]
					st_nxt.qos[QOS_OUTER_LSB +: 4] =
						fch[CH_OVLAN][15:12]; // [R9]
					st_nxt.qos[QOS_INNER_LSB +: 4] =
						fch[CH_IVLAN][15:12]; // [R10]
					st_nxt.qos[QOS_IP_LSB +: 8] =
						fch[CH_IPPRI][7:0]; // [R11]
					st_nxt.qos[QOS_SPARE_LSB +: 4] =
						fch[CH_SPARE][11:8]; // [R12]
					// uninterpreted channels pass through untouched [R7]
					st_nxt.ftype = {1'b0, fch[CH_TAG][15:14]}; // [R13]
					st_nxt.vtype = fch[CH_TAG][13:12]; // [R22]
					st_nxt.user = fch[CH_TAG][7:0]; // [R22]
					st_nxt.ovid = fch[CH_OVLAN][11:0]; // [R14]
					// inner id shares the inner priority's channel [R15]
					st_nxt.ivid = fch[CH_IVLAN][11:0]; // [R15]
					// non-zero value is the microcode's promise [R16]
					st_nxt.src_tag = fch[CH_SRC_TAG];
					st_nxt.dst_tag = fch[CH_DST_TAG]; // [R22]
					st_nxt.dmac = {fch[CH_DMAC_HI],
						fch[CH_DMAC_MID],
						fch[CH_DMAC_LO]}; // [R21]
					st_nxt.smac = {fch[CH_SMAC_HI],
						fch[CH_SMAC_MID],
						fch[CH_SMAC_LO]}; // [R21]
					st_nxt.etype = fch[CH_ETYPE]; // [R22]
					st_nxt.flow = {fch[CH_IPPRI][15:12],
						fch[CH_FLOW_LO]}; // [R17]
					st_nxt.iplen = fch[CH_IPLEN]; // [R18]
					st_nxt.hop = fch[CH_L4][15:8]; // [R22]
					st_nxt.l4 = fch[CH_L4][7:0]; // [R19]
				end
			end
			default: begin
				st_nxt.st = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_r <= '{st: ST_IDLE, sum: CSUM_INIT, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs come straight from the state flip-flops
	assign BUSY = (st_r.st == ST_BUSY);
	assign RESULT_VALID = (st_r.st == ST_DONE);
	assign FLAGS_OUT = st_r.flags_out;
	// forwarded bits steer later fixed-function stages [R5]
	assign ACTION_FLAGS = st_r.flags_out & FWD_MASK; // [R5]
	assign QOS = st_r.qos;
	assign TAG_FRAME_TYPE = st_r.ftype;
	assign TAG_VLAN_TYPE = st_r.vtype;
	assign TAG_USER_BITS = st_r.user;
	assign OUTER_VLAN_ID = st_r.ovid;
	assign INNER_VLAN_ID = st_r.ivid;
	assign SOURCE_PORT_TAG = st_r.src_tag;
	assign DEST_PORT_TAG = st_r.dst_tag;
	assign DEST_MAC_CHAN = st_r.dmac;
	assign SOURCE_MAC_CHAN = st_r.smac;
	assign ETHERTYPE_CHAN = st_r.etype;
	assign FLOW_LABEL_CHAN = st_r.flow;
	assign IP_LENGTH_CHAN = st_r.iplen;
	assign HOP_LIMIT_CHAN = st_r.hop;
	assign L4_PROTOCOL_CHAN = st_r.l4;

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	sequence s_end;
		st_r.st == ST_BUSY && FRAME_END;
	endsequence

	sequence s_end_good;
		s_end ##0 flags_step[FLAG_CSUM_BIT] && st_nxt.sum == CSUM_GOOD;
	endsequence

	sequence s_end_bad;
		s_end ##0 flags_step[FLAG_CSUM_BIT] && st_nxt.sum != CSUM_GOOD;
	endsequence

	csum_clear_a: assert property (s_end_good |=> // [R1]
		RESULT_VALID && !FLAGS_OUT[FLAG_CSUM_BIT])
		else $error("checksum flag not cleared on good sum");

	csum_keep_a: assert property (s_end_bad |=> // [R1]
		RESULT_VALID && FLAGS_OUT[FLAG_CSUM_BIT])
		else $error("checksum flag lost on bad sum");

	sequence s_len_fail;
		step && LENGTH_CHECK_FAIL;
	endsequence

	short_set_a: assert property (s_len_fail |=> // [R2]
		st_r.flags[FLAG_SHORT_BIT] && (BUSY || FLAGS_OUT[FLAG_SHORT_BIT]))
		else $error("length failure did not raise short header flag");

	parity_set_a: assert property (s_end ##0 TABLE_PARITY_ERR // [R3]
		|=> FLAGS_OUT[FLAG_PARITY_BIT])
		else $error("parity error not reported");

	flag_hold_a: assert property (BUSY && !step && !TABLE_PARITY_ERR // [R4]
		&& !FRAME_END |=> st_r.flags == $past(st_r.flags))
		else $error("flags changed without an action");

	fwd_bits_a: assert property (RESULT_VALID |-> // [R5]
		ACTION_FLAGS == (FLAGS_OUT & FWD_MASK))
		else $error("action flags do not follow header flags");

	qos_map_a: assert property (s_end |=> QOS == // [R8]
		{$past(FIELDS[CH_TAG*CHAN_W+8 +: 4]),
		$past(FIELDS[CH_OVLAN*CHAN_W+12 +: 4]),
		$past(FIELDS[CH_IVLAN*CHAN_W+12 +: 4]),
		$past(FIELDS[CH_IPPRI*CHAN_W +: 8]),
		$past(FIELDS[CH_SPARE*CHAN_W+8 +: 4])})
		else $error("qos vector misrouted");

	vlan_map_a: assert property (s_end |=> // [R15]
		INNER_VLAN_ID == $past(FIELDS[CH_IVLAN*CHAN_W +: 12]) &&
		OUTER_VLAN_ID == $past(FIELDS[CH_OVLAN*CHAN_W +: 12]) &&
		TAG_FRAME_TYPE[1:0] == $past(FIELDS[CH_TAG*CHAN_W+14 +: 2]))
		else $error("vlan or tag type misrouted");

	flow_map_a: assert property (s_end |=> // [R17]
		FLOW_LABEL_CHAN == {$past(FIELDS[CH_IPPRI*CHAN_W+12 +: 4]),
		$past(FIELDS[CH_FLOW_LO*CHAN_W +: 16])} &&
		IP_LENGTH_CHAN == $past(FIELDS[CH_IPLEN*CHAN_W +: 16]) &&
		L4_PROTOCOL_CHAN == $past(FIELDS[CH_L4*CHAN_W +: 8]))
		else $error("ip channels misrouted");

	mac_map_a: assert property (s_end |=> // [R21]
		DEST_MAC_CHAN[47:32] == $past(FIELDS[CH_DMAC_HI*CHAN_W +: 16]) &&
		SOURCE_MAC_CHAN[15:0] == $past(FIELDS[CH_SMAC_LO*CHAN_W +: 16]))
		else $error("mac channels misrouted");

	sum_step_a: assert property (step && !FRAME_END |=> // [R20]
		st_r.sum == $past(sum_upd))
		else $error("running checksum not updated");

	term_freeze_a: assert property (BUSY && st_r.term && !FRAME_END // [R20]
		|=> st_r.sum == $past(st_r.sum))
		else $error("checksum moved after terminate");

	done_pulse_a: assert property (RESULT_VALID |=> !RESULT_VALID)
		else $error("result valid longer than one cycle");
endmodule : pfa_top
`default_nettype wire

// file: inc/pfa_pkg.sv
// constants for the parser flag and field association block
//
// Contract
// R1 - checksum flag bit 37 is cleared when final ones-complement sum equals ffff
// R2 - any failed slice valid-byte length check raises short header flag bit 38
// R3 - a slice memory parity error raises table parity flag bit 39
// R4 - all other flag bits change only through the flag set action
// R5 - parser flag bits are forwarded as downstream action bits
// R6 - association only routes field channels; only qos is composed; the code also composes the flow label
// R7 - channels without fixed meaning get no hardware interpretation
// R8 - qos is 24 bits; switch tag priority from channel 0 bits 11:8
// R9 - outer vlan priority from channel 1 bits 15:12
// R10 - inner vlan priority from channel 2 bits 15:12
// R11 - ip priority from channel 16 bits 7:0
// R12 - spare priority from channel 11 bits 11:8
// R13 - tag frame type from channel 0 bits 15:14, uninterpreted
// R14 - outer vlan id from channel 1 bits 11:0
// R15 - inner vlan id from channel 2 bits 11:0, same channel as inner priority
// R16 - microcode keeps the source port tag from channel 3 non-zero
// R17 - flow label is channel 16 bits 15:12 above all of channel 17
// R18 - ip length is channel 18
// R19 - layer-4 protocol is channel 19 bits 7:0
// R20 - each slice selects whether its low and high halves join the checksum
// R21 - mac addresses come from channels 7,6,5 and 14,13,12, high first
// R22 - port tag, ethertype, hop limit, vlan type, user byte fixed routes
package pfa_pkg;
	localparam int FLAG_W = 48;
	localparam int FLAG_CSUM_BIT = 37;
	localparam int FLAG_SHORT_BIT = 38;
	localparam int FLAG_PARITY_BIT = 39;
	localparam logic [15:0] CSUM_GOOD = 16'hffff;
	localparam logic [15:0] CSUM_INIT = 16'h0000;
	localparam int NUM_CHAN = 43;
	localparam int CHAN_W = 16;
	localparam int QOS_W = 24;
	// field channel indices
	localparam int CH_TAG = 0;
	localparam int CH_OVLAN = 1;
	localparam int CH_IVLAN = 2;
	localparam int CH_SRC_TAG = 3;
	localparam int CH_DST_TAG = 4;
	localparam int CH_DMAC_LO = 5;
	localparam int CH_DMAC_MID = 6;
	localparam int CH_DMAC_HI = 7;
	localparam int CH_SPARE = 11;
	localparam int CH_SMAC_LO = 12;
	localparam int CH_SMAC_MID = 13;
	localparam int CH_SMAC_HI = 14;
	localparam int CH_ETYPE = 15;
	localparam int CH_IPPRI = 16;
	localparam int CH_FLOW_LO = 17;
	localparam int CH_IPLEN = 18;
	localparam int CH_L4 = 19;
	// qos vector layout, msb first
	localparam int QOS_SW_LSB = 20;
	localparam int QOS_OUTER_LSB = 16;
	localparam int QOS_INNER_LSB = 12;
	localparam int QOS_IP_LSB = 4;
	localparam int QOS_SPARE_LSB = 0;
endpackage : pfa_pkg

// file: rtl/pfa_csum_add.sv
// ones-complement adder folding up to two halfwords into a running sum
`timescale 1ns/1ps
`default_nettype none
module pfa_csum_add (
	// running sum
	input wire logic [15:0] acc,
	// halfwords of the slice window and their enables
	input wire logic [15:0] low_half,
	input wire logic [15:0] high_half,
	input wire logic low_en,
	input wire logic high_en,
	// updated sum
	output logic [15:0] sum
);
	logic [16:0] s1;
	logic [15:0] f1;
	logic [16:0] s2;

	// end-around carry after each addition keeps the sum ones-complement
	always_comb begin
		s1 = {1'b0, acc} + {1'b0, (low_en ? low_half : 16'h0000)};
		f1 = s1[15:0] + {15'h0000, s1[16]};
		s2 = {1'b0, f1} + {1'b0, (high_en ? high_half : 16'h0000)};
		sum = s2[15:0] + {15'h0000, s2[16]};
	end
endmodule : pfa_csum_add
`default_nettype wire

// file: sim/pfa_sink.sv
// downstream stage model: counts results and keeps the forwarded flags
`timescale 1ns/1ps
`default_nettype none
module pfa_sink (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// result from the association stage
	input wire logic valid,
	input wire logic [47:0] act,
	// what the stage has seen
	output logic [47:0] last_act,
	output int frames
);
	// take flags only on the valid pulse; between pulses the bus means nothing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frames <= 0;
			last_act <= '0;
		end else if (valid) begin
			frames <= frames + 1;
			last_act <= act;
		end
	end
endmodule : pfa_sink
`default_nettype wire

// file: sim/pfa_top_test.sv
// self-checking bench for the parser flags and association stage
`timescale 1ns/1ps
`default_nettype none
module pfa_top_test;
	import pfa_pkg::*;
	// a sparse forward mask shows that unforwarded bits are really dropped
	localparam logic [FLAG_W-1:0] MASK = 48'h00f0_ffff_0f0f;
	logic clk, nrst, fs, fe, sv, lo_en, hi_en, lf, term, par, busy, rv;
	logic [31:0] data;
	logic [47:0] act, flags, aflags, dmac, smac, s_act, last_ef;
	logic [687:0] fields;
	logic [23:0] qos;
	logic [2:0] ftype;
	logic [1:0] vtype;
	logic [7:0] user, hop, l4;
	logic [11:0] ovid, ivid;
	logic [15:0] sptag, dptag, etype, iplen;
	logic [19:0] flow;
	int error_cnt, compares, cyc, nf, s_frames;

	pfa_top #(.FWD_MASK(MASK)) pfa_top_i (.CLK(clk), .NRST(nrst),
		.FRAME_START(fs), .FRAME_END(fe), .SLICE_VALID(sv), .FRAME_DATA(data),
		.LOW_HALF_SUM_ENABLE(lo_en), .HIGH_HALF_SUM_ENABLE(hi_en),
		.FLAG_SET_ACTION(act), .LENGTH_CHECK_FAIL(lf), .SLICE_TERMINATE(term),
		.TABLE_PARITY_ERR(par), .FIELDS(fields), .BUSY(busy),
		.RESULT_VALID(rv), .FLAGS_OUT(flags), .ACTION_FLAGS(aflags),
		.QOS(qos), .TAG_FRAME_TYPE(ftype), .TAG_VLAN_TYPE(vtype),
		.TAG_USER_BITS(user), .OUTER_VLAN_ID(ovid), .INNER_VLAN_ID(ivid),
		.SOURCE_PORT_TAG(sptag), .DEST_PORT_TAG(dptag), .DEST_MAC_CHAN(dmac),
		.SOURCE_MAC_CHAN(smac), .ETHERTYPE_CHAN(etype),
		.FLOW_LABEL_CHAN(flow), .IP_LENGTH_CHAN(iplen),
		.HOP_LIMIT_CHAN(hop), .L4_PROTOCOL_CHAN(l4));
	pfa_sink pfa_sink_i (.clk(clk), .nrst(nrst), .valid(rv), .act(aflags),
		.last_act(s_act), .frames(s_frames));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	// one frame of n steps, entered at a falling edge; good forces a sum of ffff
	task automatic frame(input int n, input bit good);
		logic [15:0] f [0:42];
		logic [47:0] ef;
		int s;
		bit done;
		ef = '0;
		s = 0;
		done = 0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			f[i] = 16'($urandom) | ((i == CH_SRC_TAG) ? 16'h0001 : 16'h0000);
			fields[16*i +: 16] = f[i];
		end
		// slice strobes before the frame opens must be ignored
		fs = 1'b1;
		{sv, lf, par} = 3'b111;
		act = '1;
		@(negedge clk);
		fs = 1'b0;
		for (int k = 0; k < n; k++) begin
			sv = 1'b1;
			// a start pulse inside an open frame must be ignored
			fs = ($urandom % 4 == 0);
			fe = (k == n - 1);
			data = good ? 32'hedcb_1234 : $urandom;
			lo_en = good ? (k == 0) : 1'($urandom);
			hi_en = good ? (k == 0) : 1'($urandom);
			act = ($urandom % 3 == 0) ? {16'($urandom), 32'($urandom)} : '0;
			if (good && k == 0)
				act[FLAG_CSUM_BIT] = 1'b1;
			lf = ($urandom % 5 == 0);
			term = ($urandom % 5 == 0);
			par = ($urandom % 7 == 0);
			// steps after a terminate leave the sum and all flags but the parity flag alone
			if (!done) begin
				ef |= act;
				if (lf)
					ef[FLAG_SHORT_BIT] = 1'b1;
				if (lo_en)
					s += data[15:0];
				if (s > 'hffff)
					s -= 'hffff;
				if (hi_en)
					s += data[31:16];
				if (s > 'hffff)
					s -= 'hffff;
				done = term;
			end
			if (par)
				ef[FLAG_PARITY_BIT] = 1'b1;
			@(negedge clk);
		end
		{sv, fe, fs, lf, term, par, lo_en, hi_en} = '0;
		act = '0;
		if (ef[FLAG_CSUM_BIT] && s == 'hffff)
			ef[FLAG_CSUM_BIT] = 1'b0;
		last_ef = ef;
		nf++;
		chk({rv, busy}, 2'b10);
		chk(flags, ef);
		chk(aflags, ef & MASK);
		chk(qos, {f[0][11:8], f[1][15:12], f[2][15:12], f[16][7:0], f[11][11:8]});
		chk(ftype, {1'b0, f[0][15:14]});
		chk({vtype, user, sptag, dptag, etype}, {f[0][13:12], f[0][7:0], f[3], f[4], f[15]});
		chk({ovid, ivid}, {f[1][11:0], f[2][11:0]});
		chk({ivid, qos[15:12]}, {f[2][11:0], f[2][15:12]});
		chk(dmac, {f[7], f[6], f[5]});
		chk(smac, {f[14], f[13], f[12]});
		chk({flow, iplen}, {f[16][15:12], f[17], f[18]});
		chk({hop, l4}, f[19]);
		@(negedge clk);
		chk(rv, 1'b0);
	endtask : frame

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			finish_test();
		end
	end

	initial begin
		{nrst, fs, fe, sv, lo_en, hi_en, lf, term, par} = '0;
		data = '0;
		act = '0;
		fields = '0;
		void'($urandom(68165));
		repeat (4) @(posedge clk);
		chk({busy, rv, qos}, '0);
		chk(flags, '0);
		@(negedge clk);
		nrst = 1'b1;
		// an end pulse outside a frame must be ignored
		fe = 1'b1;
		@(negedge clk);
		fe = 1'b0;
		@(negedge clk);
		chk(rv, 1'b0);
		frame(1, 1'b1);
		frame(3, 1'b1);
		for (int i = 0; i < 40; i++)
			frame(1 + $urandom % 4, 1'b0);
		@(negedge clk);
		chk(s_frames, nf);
		chk(s_act, last_ef & MASK);
		finish_test();
	end
endmodule : pfa_top_test
`default_nettype wire
